// ### logic/irq_route.sv
// irq_route: aggregates peripheral requests into core interrupt lines, merges nmi,
// routes selectable serial requests to dma, holds priorities and an apb register file
// assumes: peripheral requests are levels on clk; the nmi pin is asynchronous
//
// Functional notes
// - peripheral requests ORed into 48 lines
// - nmi pin ORed with hardware watchdog
// - batch-read register per line shows contributors
// - batch reads never clear peripheral flags
// - route bits steer request to cpu or dma
// - type-2 extended selector picks dma source
// - extended selectors only on eight dma numbers
// - 48 peripheral channels after 16 exceptions
// - 4-bit priority per channel, 16 levels
// - vectors: stack 0x00, reset 0x04, nmi 0x08
// - irq n at 0x40 plus 4n; irq0 clock fault
// - irq1 software watchdog, irq2 low voltage
// - ext pins 0-7 irq4, 8-31 irq5
// - irq3 timer waveforms plus emergency stop
// - irq6 dual timer plus quadrature counters
// - serial k and k+8 share rx, tx lines
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "irq_route_defs.svh"

module irq_route import irq_route_pkg::*; #(
	parameter bit IS_TYPE2 = 1'b1,
	parameter int NUM_LINES = `IRQ_LINES
) (
	input wire logic clk, // 10 MHz system clock
	input wire logic rst_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error
	input wire periph_req_s req, // peripheral request levels
	input wire logic [7:0] ext_cand, // alternate dma sources
	input wire logic nonmaskable_pin_n, // nmi pin, active low
	input wire logic hw_watchdog, // hardware watchdog request
	output logic [47:0] core_irq, // aggregated lines to the core
	output logic core_nmi, // non-maskable request to the core
	output logic [31:0] dma_req, // transfer requests to dma
	output logic [47:0][3:0] core_irq_priority, // per-line priority
	output logic [7:0] pend_vector_ofs, // vector offset of winner
	output logic pend_valid, // a request is pending
	output logic evt_irq // unmasked event status
);
	localparam int EXT_MAP [8] = '{10, 11, 24, 25, 26, 27, 30, 31};

	generate
		if (NUM_LINES != `IRQ_LINES) begin : g_bad_lines
			$error("irq_route serves exactly the fixed line count");
		end
	endgenerate

	state_s s_q, s_d;
	logic [47:0][31:0] contrib;
	logic [31:0] sel;
	logic [15:0] cpu_rx, cpu_tx;
	logic acc, take, hit;
	logic [31:0] rd;

	// serial requests stand in pairs: even number receive, odd number transmit
	// a routed request adds nothing to its cpu line even while its flag stays set; the k+8 partner can still raise the shared line
	always_comb begin
		for (int k = 0; k < 16; k++) begin
			sel[2*k] = req.multifunction_serial_rx[k];
			sel[2*k+1] = req.multifunction_serial_tx[k];
			cpu_rx[k] = req.multifunction_serial_rx[k] & ~s_q.route[2*k];
			cpu_tx[k] = req.multifunction_serial_tx[k] & ~s_q.route[2*k+1];
		end
	end

	// an extended source replaces the serial request but still needs its route bit,
	// so clearing the route bit alone hands the dma number back to the cpu side
	always_comb begin
		dma_req = sel & s_q.route;
		for (int e = 0; e < 8; e++) begin
			if (IS_TYPE2 && s_q.ext[e]) begin
				dma_req[EXT_MAP[e]] = ext_cand[e] & s_q.route[EXT_MAP[e]];
			end
		end
	end

	// plain wiring, no flops: a cleared peripheral flag drops its line at once
	always_comb begin
		contrib = '0;
		contrib[`IRQ_CLK_FAULT][0] = req.clock_supervisor_freq_fault;
		contrib[`IRQ_SWDT][0] = req.swdt;
		contrib[`IRQ_LOW_VOLT][0] = req.low_voltage_detector;
		contrib[`IRQ_WFG][3:0] = {req.motor_emergency_stop, req.multifunction_timer_wfg};
		contrib[`IRQ_EXT_LO][7:0] = req.ext_pin[7:0];
		contrib[`IRQ_EXT_HI][23:0] = req.ext_pin[31:8];
		contrib[`IRQ_DTQ][3:0] = {req.quadrature_counter, req.dual_timer};
		for (int k = 0; k < 8; k++) begin
			contrib[`IRQ_SERIAL_RX0+2*k][1:0] = {cpu_rx[k+8], cpu_rx[k]};
			contrib[`IRQ_SERIAL_RX0+2*k+1][1:0] = {cpu_tx[k+8], cpu_tx[k]};
		end
		for (int i = `IRQ_MISC0; i < `IRQ_LINES; i++) begin
			contrib[i][0] = req.misc[i-`IRQ_MISC0];
		end
		for (int i = 0; i < `IRQ_LINES; i++) begin
			core_irq[i] = |contrib[i];
		end
	end

	// the second flop is the only reader of the first
	assign core_nmi = ~s_q.nmi_s2 | hw_watchdog;

	// writes land on the ready edge, the same edge at which the master sees pready
	assign acc = psel & penable;
	assign take = acc & s_q.rdy;

	// reads latch in the first access cycle, so every transfer has one wait state
	always_comb begin
		hit = 1'b1;
		rd = 32'h0000_0000;
		if (paddr[1:0] != 2'b00) begin
			hit = 1'b0;
		end else if (paddr == `OFS_ROUTE_LOW) begin
			rd[15:0] = s_q.route[15:0];
		end else if (paddr == `OFS_ROUTE_HIGH) begin
			rd[15:0] = s_q.route[31:16];
		end else if (paddr == `OFS_EXT_SEL) begin
			rd[7:0] = IS_TYPE2 ? s_q.ext : 8'h00;
		end else if (paddr == `OFS_EVT_STATUS) begin
			rd[2:0] = s_q.status;
		end else if (paddr == `OFS_EVT_MASK) begin
			rd[2:0] = s_q.mask;
		end else if (paddr[11:8] == `PAGE_BATCH && paddr[7:2] < 6'(`IRQ_LINES)) begin
			rd = contrib[paddr[7:2]];
		end else if (paddr[11:8] == `PAGE_PRIO && paddr[7:2] < `PRIO_WORDS) begin
			rd = s_q.prio[8*paddr[7:2] +: 8];
		end else begin
			hit = 1'b0;
		end
	end

	always_comb begin
		logic [4:0] best;
		logic [5:0] idx;
		logic [2:0] set, clr;
		best = 5'h10;
		idx = 6'h00;
		set = 3'h0;
		clr = 3'h0;
		s_d = s_q;
		s_d.nmi_s1 = nonmaskable_pin_n;
		s_d.nmi_s2 = s_q.nmi_s1;
		s_d.nmi_prev = core_nmi;
		s_d.drq_prev = |dma_req;
		s_d.rdy = acc & ~s_q.rdy;
		if (acc && !s_q.rdy) begin
			s_d.rdata = pwrite ? 32'h0000_0000 : rd;
			s_d.bad = ~hit;
		end
		if (take && pwrite && hit) begin
			if (paddr == `OFS_ROUTE_LOW) begin
				s_d.route[15:0] = pwdata[15:0];
			end
			if (paddr == `OFS_ROUTE_HIGH) begin
				s_d.route[31:16] = pwdata[15:0];
			end
			if (paddr == `OFS_EXT_SEL && IS_TYPE2) begin
				s_d.ext = pwdata[7:0];
			end
			if (paddr == `OFS_EVT_STATUS) begin
				clr = pwdata[2:0];
			end
			if (paddr == `OFS_EVT_MASK) begin
				s_d.mask = pwdata[2:0];
			end
			if (paddr[11:8] == `PAGE_PRIO) begin
				s_d.prio[8*paddr[7:2] +: 8] = pwdata;
			end
		end
		set[`EVT_NMI] = core_nmi & ~s_q.nmi_prev;
		set[`EVT_DRQ] = (|dma_req) & ~s_q.drq_prev;
		set[`EVT_BUSERR] = take & s_q.bad;
		// a new event beats a clear written in the same cycle
		s_d.status = (s_q.status & ~clr) | set;
		// lowest value wins; strict compare leaves ties with the lower line number
		for (int i = 0; i < `IRQ_LINES; i++) begin
			if (core_irq[i] && {1'b0, s_q.prio[i]} < best) begin
				best = {1'b0, s_q.prio[i]};
				idx = 6'(i);
			end
		end
		s_d.vec_valid = core_nmi | ~best[4];
		if (core_nmi) begin
			s_d.vec = `VEC_NMI;
		end else if (!best[4]) begin
			s_d.vec = `VEC_IRQ_BASE + {idx, 2'b00};
		end else begin
			s_d.vec = `VEC_RESET;
		end
	end

	// the whole record moves at once; the reset branch loads constants only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q.route <= `RST_ROUTE;
			s_q.ext <= `RST_EXT;
			s_q.prio <= {`IRQ_LINES{`RST_PRIO}};
			s_q.status <= 3'h0;
			s_q.mask <= `RST_MASK;
			s_q.nmi_s1 <= 1'b1;
			s_q.nmi_s2 <= 1'b1;
			s_q.nmi_prev <= 1'b0;
			s_q.drq_prev <= 1'b0;
			s_q.rdy <= 1'b0;
			s_q.bad <= 1'b0;
			s_q.rdata <= 32'h0000_0000;
			s_q.vec <= `VEC_SP;
			s_q.vec_valid <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pready = s_q.rdy;
	assign prdata = s_q.rdata;
	assign pslverr = s_q.rdy & s_q.bad;
	assign core_irq_priority = s_q.prio;
	assign pend_vector_ofs = s_q.vec;
	assign pend_valid = s_q.vec_valid;
	assign evt_irq = |(s_q.status & s_q.mask);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_nmi_watchdog: assert property (hw_watchdog |-> core_nmi)
		else $error("watchdog request missing on nmi");
	a_nmi_pin: assert property (!nonmaskable_pin_n [*3] |-> core_nmi)
		else $error("held nmi pin not delivered");
	a_batch_line: assert property (acc && !s_q.rdy && !pwrite && paddr == 12'h110
		|=> prdata[7:0] == $past(req.ext_pin[7:0]))
		else $error("batch read of ext pin line wrong");
	a_batch_quiet: assert property (acc && !pwrite && paddr[11:8] == `PAGE_BATCH
		|=> $stable(s_q.route) && $stable(s_q.prio))
		else $error("batch read changed state");
	a_route_write: assert property (take && pwrite && paddr == `OFS_ROUTE_LOW
		|=> s_q.route[15:0] == $past(pwdata[15:0]))
		else $error("route select write lost");
	a_route_excl: assert property (s_q.route[0] && !req.multifunction_serial_rx[8]
		|-> !core_irq[`IRQ_SERIAL_RX0])
		else $error("dma routed request reached cpu");
	a_ext_pick: assert property (IS_TYPE2 && s_q.ext[0] && s_q.route[10]
		|-> dma_req[10] == ext_cand[0])
		else $error("extended source not selected");
	a_fixed_src: assert property (dma_req[0] ==
		(req.multifunction_serial_rx[0] & s_q.route[0]))
		else $error("fixed dma source altered");
	a_vec_nmi: assert property (core_nmi |=> pend_vector_ofs == `VEC_NMI)
		else $error("nmi vector offset wrong");
	a_vec_irq0: assert property (core_irq[0] && !core_nmi && s_q.prio[0] == 4'h0
		|=> pend_vector_ofs == `VEC_IRQ_BASE && pend_valid)
		else $error("irq0 vector offset wrong");
	a_wfg_or: assert property ($rose(req.motor_emergency_stop) |-> core_irq[`IRQ_WFG])
		else $error("emergency stop missing on its line");

	// fixed wiring of lines 0-6, two serial lines and the misc lines
	a_fault_line: assert property (req.clock_supervisor_freq_fault
		|-> core_irq[`IRQ_CLK_FAULT])
		else $error("clock fault line missing");
	a_swdt_line: assert property (req.swdt
		|-> core_irq[`IRQ_SWDT])
		else $error("software watchdog line missing");
	a_lvd_line: assert property (req.low_voltage_detector
		|-> core_irq[`IRQ_LOW_VOLT])
		else $error("low voltage line missing");
	a_wfg_all: assert property (core_irq[`IRQ_WFG] ==
		(req.motor_emergency_stop | (|req.multifunction_timer_wfg)))
		else $error("timer waveform line wrong");
	a_ext_low: assert property (core_irq[`IRQ_EXT_LO] ==
		(|req.ext_pin[7:0]))
		else $error("low pin group line wrong");
	a_ext_high: assert property (core_irq[`IRQ_EXT_HI] ==
		(|req.ext_pin[31:8]))
		else $error("high pin group line wrong");
	a_dtq_or: assert property (core_irq[`IRQ_DTQ] ==
		(req.dual_timer | (|req.quadrature_counter)))
		else $error("dual timer line wrong");
	a_serial_rx: assert property (req.multifunction_serial_rx[9] && !s_q.route[18]
		|-> core_irq[`IRQ_SERIAL_RX0+2])
		else $error("paired receive line missing");
	a_serial_tx: assert property (req.multifunction_serial_tx[15] && !s_q.route[31]
		|-> core_irq[`IRQ_SERIAL_RX0+15])
		else $error("paired transmit line missing");
	a_misc_lines: assert property (core_irq[46:`IRQ_MISC0] == req.misc[23:0])
		else $error("misc lines wrong");
	a_misc_top: assert property (core_irq[`IRQ_LINES-1] == req.misc[24])
		else $error("last line wrong");

	// routing and extended selection
	a_rx_excl: assert property (s_q.route[10] && !req.multifunction_serial_rx[13]
		|-> !core_irq[`IRQ_SERIAL_RX0+10])
		else $error("routed receive reached cpu");
	a_fixed_dma: assert property (dma_req[13] ==
		(req.multifunction_serial_tx[6] & s_q.route[13]))
		else $error("fixed transmit dma source altered");
	a_ext_off: assert property (!s_q.ext[0]
		|-> dma_req[10] == (req.multifunction_serial_rx[5] & s_q.route[10]))
		else $error("plain source lost without selector");

	// priorities, a batch read, vectors, nmi and events
	a_prio_write: assert property (take && pwrite && paddr == 12'h200
		|=> core_irq_priority[0] == $past(pwdata[3:0]))
		else $error("priority write lost");
	a_prio_read: assert property (acc && !s_q.rdy && !pwrite && paddr == 12'h200
		|=> prdata[3:0] == $past(core_irq_priority[0]))
		else $error("priority read wrong");
	a_batch_high: assert property (acc && !s_q.rdy && !pwrite && paddr == 12'h114
		|=> prdata[23:0] == $past(req.ext_pin[31:8]))
		else $error("batch read of high pin line wrong");
	a_vec_idle: assert property (!core_nmi && core_irq == '0
		|=> pend_vector_ofs == `VEC_RESET && !pend_valid)
		else $error("idle vector wrong");
	a_vec_swdt: assert property (core_irq[`IRQ_SWDT] && !core_irq[`IRQ_CLK_FAULT]
		&& !core_nmi && s_q.prio[`IRQ_SWDT] == 4'h0
		|=> pend_vector_ofs == `VEC_IRQ_BASE + 8'h04)
		else $error("software watchdog vector wrong");
	a_vec_valid: assert property (core_nmi |=> pend_valid)
		else $error("nmi not pending");
	a_nmi_quiet: assert property (nonmaskable_pin_n [*3] ##0 !hw_watchdog
		|-> !core_nmi)
		else $error("idle nmi pin raised nmi");
	a_nmi_event: assert property (core_nmi && !s_q.nmi_prev
		|=> s_q.status[`EVT_NMI])
		else $error("nmi event not recorded");

	c_nmi_seen: cover property ($rose(core_nmi));
	c_dma_route: cover property ($rose(|dma_req));
	c_batch_read: cover property (take && !pwrite && paddr[11:8] == `PAGE_BATCH);
	c_evt_irq: cover property ($rose(evt_irq));
	c_ext_pick: cover property (s_q.ext[0] && dma_req[10]);
endmodule

`default_nettype wire

// ### logic/irq_route_defs.svh
// irq_route_defs.svh: offsets, reset values and fixed numbers of the interrupt router
// assumes: included by bare name after the package, apb byte addresses on paddr[11:0]
`ifndef IRQ_ROUTE_DEFS_SVH
`define IRQ_ROUTE_DEFS_SVH
`define IRQ_LINES 48
`define PRIO_BITS 4
`define DRQ_LINES 32
`define EXT_SEL_BITS 8
`define EVT_BITS 3
`define EVT_NMI 0
`define EVT_DRQ 1
`define EVT_BUSERR 2
`define OFS_ROUTE_LOW 12'h000
`define OFS_ROUTE_HIGH 12'h004
`define OFS_EXT_SEL 12'h008
`define OFS_EVT_STATUS 12'h00c
`define OFS_EVT_MASK 12'h010
`define PAGE_BATCH 4'h1
`define PAGE_PRIO 4'h2
`define PRIO_WORDS 6'h0c
`define VEC_SP 8'h00
`define VEC_RESET 8'h04
`define VEC_NMI 8'h08
`define VEC_IRQ_BASE 8'h40
`define IRQ_CLK_FAULT 0
`define IRQ_SWDT 1
`define IRQ_LOW_VOLT 2
`define IRQ_WFG 3
`define IRQ_EXT_LO 4
`define IRQ_EXT_HI 5
`define IRQ_DTQ 6
`define IRQ_SERIAL_RX0 7
`define IRQ_MISC0 23
`define RST_ROUTE 32'h0000_0000
`define RST_EXT 8'h00
`define RST_PRIO 4'h0
`define RST_MASK 3'h0
`endif

// ### logic/irq_route_pkg.sv
// irq_route_pkg: carrier structs and the state record of the interrupt router
// assumes: compiled before the router module
`default_nettype none
package irq_route_pkg;
	typedef struct packed {
		logic clock_supervisor_freq_fault;
		logic swdt;
		logic low_voltage_detector;
		logic [2:0] multifunction_timer_wfg;
		logic motor_emergency_stop;
		logic [31:0] ext_pin;
		logic dual_timer;
		logic [2:0] quadrature_counter;
		logic [15:0] multifunction_serial_rx;
		logic [15:0] multifunction_serial_tx;
		logic [24:0] misc;
	} periph_req_s;
	typedef struct packed {
		logic [31:0] route;
		logic [7:0] ext;
		logic [47:0][3:0] prio;
		logic [2:0] status;
		logic [2:0] mask;
		logic nmi_s1;
		logic nmi_s2;
		logic nmi_prev;
		logic drq_prev;
		logic rdy;
		logic bad;
		logic [31:0] rdata;
		logic [7:0] vec;
		logic vec_valid;
	} state_s;
endpackage
`default_nettype wire

// ### tb/core_dma_model.sv
// core_dma_model: stands for the core interrupt controller and the dma engine
// assumes: watches the router outputs on the router's own clock
`timescale 1ns/1ns
`default_nettype none
module core_dma_model (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [47:0] core_irq, // aggregated lines
	input wire logic core_nmi, // non-maskable request
	input wire logic [31:0] dma_req, // transfer requests
	output logic [7:0] dma_starts, // new dma activity seen
	output logic [7:0] cpu_starts // new cpu interrupt work seen
);
	logic any_q, cpu_q;
	// dma takes levels; counting rises shows whether a request was seen as new work
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			any_q <= 1'b0;
			cpu_q <= 1'b0;
			dma_starts <= 8'h00;
			cpu_starts <= 8'h00;
		end else begin
			any_q <= |dma_req;
			cpu_q <= (|core_irq) | core_nmi;
			if (|dma_req && !any_q)
				dma_starts <= dma_starts + 8'h01;
			if (((|core_irq) || core_nmi) && !cpu_q)
				cpu_starts <= cpu_starts + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ### tb/interrupt_aggregation_dma_routing_tb_top.sv
// testbench: apb register access and request stimulus around the interrupt router
// assumes: router with default parameters, one 10 MHz clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module interrupt_aggregation_dma_routing_tb_top import irq_route_pkg::*;;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, nmi_n = 1, hw_wd = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r, dma_req;
	logic pready, pslverr, last_err, core_nmi, pend_valid, evt_irq;
	logic [7:0] ext_cand = '0, pvo, starts, cpu_starts;
	logic [47:0] core_irq;
	logic [47:0][3:0] prio;
	periph_req_s req = '0, v;
	logic [11:0] regs [6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h200};
	int num_errors = 0, tests_run = 0;
	irq_route uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.req(req), .ext_cand(ext_cand), .nonmaskable_pin_n(nmi_n), .hw_watchdog(hw_wd),
		.core_irq(core_irq), .core_nmi(core_nmi), .dma_req(dma_req), .core_irq_priority(prio),
		.pend_vector_ofs(pvo), .pend_valid(pend_valid), .evt_irq(evt_irq));
	core_dma_model partner (.clk(clk), .rst_n(rst_n), .core_irq(core_irq), .core_nmi(core_nmi),
		.dma_req(dma_req), .dma_starts(starts), .cpu_starts(cpu_starts));
	always #50 clk = ~clk;
	task automatic end_sim;
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// request held until ready is seen; data taken in the ready cycle
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				num_errors++;
				end_sim();
			end
		end while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	// two edges: lines are combinational, the pending vector lags by one register
	task automatic drive(input periph_req_s x);
		@(posedge clk);
		req <= x;
		@(negedge clk);
		@(negedge clk);
	endtask
	task automatic agg(input int i);
		int ln;
		v = '0;
		case (i)
			0: begin v.clock_supervisor_freq_fault = 1'b1; ln = 0; end
			1: begin v.swdt = 1'b1; ln = 1; end
			2: begin v.low_voltage_detector = 1'b1; ln = 2; end
			3: begin v.multifunction_timer_wfg[2] = 1'b1; ln = 3; end
			4: begin v.motor_emergency_stop = 1'b1; ln = 3; end
			5: begin v.ext_pin[7] = 1'b1; ln = 4; end
			6: begin v.ext_pin[8] = 1'b1; ln = 5; end
			7: begin v.dual_timer = 1'b1; ln = 6; end
			8: begin v.quadrature_counter[2] = 1'b1; ln = 6; end
			9: begin v.multifunction_serial_rx[9] = 1'b1; ln = 9; end
			10: begin v.multifunction_serial_tx[15] = 1'b1; ln = 22; end
			default: begin v.misc[24] = 1'b1; ln = 47; end
		endcase
		drive(v);
		`CHK(core_irq, 48'h1 << ln)
		`CHK({pend_valid, pvo}, {1'b1, 8'(8'h40 + 4 * ln)})
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		foreach (regs[k]) begin
			bus(1'b0, regs[k], '0, r);
			`CHK(r, 32'h0)
		end
		for (int i = 0; i < 12; i++)
			agg(i);
		drive('0);
		`CHK({pend_valid, pvo}, 9'h004)
		v = '0;
		v.ext_pin[20] = 1'b1;
		v.ext_pin[3] = 1'b1;
		drive(v);
		bus(1'b0, 12'h114, '0, r);
		`CHK(r, 32'h1000)
		bus(1'b0, 12'h114, '0, r);
		`CHK({core_irq[5], r}, 33'h1_0000_1000)
		bus(1'b0, 12'h110, '0, r);
		`CHK({core_irq[4], r}, 33'h1_0000_0008)
		wr(12'h200, 32'hf);
		`CHK(prio[0], 4'hf)
		v = '0;
		v.clock_supervisor_freq_fault = 1'b1;
		v.swdt = 1'b1;
		drive(v);
		`CHK(pvo, 8'h44)
		wr(12'h000, 32'h401);
		v = '0;
		v.multifunction_serial_rx[0] = 1'b1;
		drive(v);
		`CHK({core_irq[7], dma_req}, 33'h1)
		wr(12'h008, 32'h1);
		@(posedge clk);
		ext_cand <= 8'h01;
		@(negedge clk);
		`CHK({starts, dma_req}, 40'h01_0000_0401)
		drive('0);
		@(posedge clk);
		nmi_n <= 1'b0;
		repeat (4) @(negedge clk);
		`CHK({core_nmi, pvo}, 9'h108)
		@(posedge clk);
		nmi_n <= 1'b1;
		hw_wd <= 1'b1;
		repeat (4) @(negedge clk);
		`CHK(core_nmi, 1'b1)
		bus(1'b0, 12'h7fc, '0, r);
		`CHK({last_err, r}, 33'h1_0000_0000)
		bus(1'b0, 12'h00c, '0, r);
		`CHK({evt_irq, r}, 33'h7)
		wr(12'h010, 32'h4);
		@(negedge clk);
		`CHK(evt_irq, 1'b1)
		wr(12'h00c, 32'h4);
		bus(1'b0, 12'h00c, '0, r);
		`CHK({evt_irq, r}, 33'h3)
		`CHK(cpu_starts, 8'h03)
		end_sim();
	end
endmodule
`default_nettype wire
